// ---- lfo_divider.sv ----
`default_nettype none
// Glitch-free divider of the oscillator enable ticks; it produces the
// divided clock level and one-cycle pulses at its rising and falling edges.
module lfo_divider
   import lfo_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic tick_in,
   input wire logic [1:0] div_sel_in,
   output logic level_out,
   output logic rise_out,
   output logic fall_out
);
   // Free-running count of raw oscillator half-period ticks.
   logic [3:0] count;
   // Selection in force; it only changes at a boundary of the slowest
   // division so the output never shows a runt pulse.
   logic [1:0] active_sel;
   logic next_level;

   // The output bit follows the count bit that matches the selection.
   always_comb begin
      unique case (active_sel)
         DIV_BY_8: next_level = count[3];
         DIV_BY_4: next_level = count[2];
         DIV_BY_2: next_level = count[1];
         DIV_BY_1: next_level = count[0];
      endcase
   end

   // Count raw ticks; the selection is latched only when the count wraps.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         count <= 4'h0;
         active_sel <= DIV_RESET;
      end else if (tick_in) begin
         count <= count + 4'h1;
         if (count == 4'hF) begin
            active_sel <= div_sel_in;
         end
      end
   end

   // Output level register and edge pulses for capture logic.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         level_out <= 1'b0;
         rise_out <= 1'b0;
         fall_out <= 1'b0;
      end else begin
         level_out <= next_level;
         rise_out <= next_level & ~level_out;
         fall_out <= ~next_level & level_out;
      end
   end
endmodule
`default_nettype wire

// ---- lfo_pkg.sv ----
`default_nettype none
package lfo_pkg;
   // Special-function register address of the control register.
   localparam logic [7:0] LFO_CTRL_ADDR = 8'h86;
   // Field positions within the control register.
   localparam int ON_BIT = 7;
   localparam int STABLE_BIT = 6;
   localparam int TUNE_LSB = 2;
   localparam int DIV_LSB = 0;
   // Values after reset.
   localparam logic ON_RESET = 1'h0;
   localparam logic [3:0] TUNE_RESET = 4'h0;
   localparam logic [1:0] DIV_RESET = 2'h0;
   // Divider select codes.
   localparam logic [1:0] DIV_BY_8 = 2'h0;
   localparam logic [1:0] DIV_BY_4 = 2'h1;
   localparam logic [1:0] DIV_BY_2 = 2'h2;
   localparam logic [1:0] DIV_BY_1 = 2'h3;
   // Nominal oscillator rate and the system clock rate.
   localparam int LFO_NOMINAL_KHZ = 80;
   localparam int CLK_KHZ = 50000;
   // Base half period in system cycles at the fastest tune setting.
   localparam int HALF_BASE_CYCLES = CLK_KHZ / (2 * LFO_NOMINAL_KHZ);
   // Extra half-period cycles added per tune step.
   localparam int TUNE_STEP_CYCLES = 8;
   // Number of raw oscillator half-period ticks before the output counts as stable.
   localparam int SETTLE_CYCLES = 16;
endpackage
`default_nettype wire

// ---- lowfreq_osc_control.sv ----
`default_nettype none
module lowfreq_osc_control
   import lfo_pkg::*;
#(
   parameter int COUNT_WIDTH = 16
)(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_wr_in,
   input wire logic [7:0] sfr_wdata_in,
   output logic [7:0] sfr_rdata_out,
   input wire logic t2_capture_mode_in,
   input wire logic t3_capture_mode_in,
   input wire logic [COUNT_WIDTH-1:0] t2_count_in,
   input wire logic [COUNT_WIDTH-1:0] t3_count_in,
   output logic [COUNT_WIDTH-1:0] t2_reload_out,
   output logic [COUNT_WIDTH-1:0] t3_reload_out,
   output logic t2_capture_out,
   output logic t3_capture_out,
   output logic lfo_clk_out
);
   // Control register fields.
   logic lowfreq_osc_on;
   logic [3:0] lowfreq_fine_tune;
   logic [1:0] lowfreq_div_sel;
   // Ready flag and its two-stage synchroniser.
   logic lowfreq_osc_stable;
   logic stable_meta;
   logic stable_sync;
   // Oscillator model: half-period counter and raw tick.
   logic [11:0] half_count;
   logic [11:0] half_limit;
   logic raw_tick;
   // Settling counter of raw ticks since reset or divider change.
   logic [4:0] settle_count;
   logic ctrl_write;
   logic div_change;
   logic div_rise;
   logic div_fall;

   assign ctrl_write = sfr_wr_in && (sfr_addr_in == LFO_CTRL_ADDR);
   assign div_change = ctrl_write &&
      (sfr_wdata_in[DIV_LSB +: 2] != lowfreq_div_sel);

   // Register writes; the ready bit is read-only and ignores writes.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         lowfreq_osc_on <= ON_RESET;
         lowfreq_fine_tune <= TUNE_RESET;
         lowfreq_div_sel <= DIV_RESET;
      end else if (ctrl_write) begin
         lowfreq_osc_on <= sfr_wdata_in[ON_BIT];
         lowfreq_fine_tune <= sfr_wdata_in[TUNE_LSB +: 4];
         lowfreq_div_sel <= sfr_wdata_in[DIV_LSB +: 2];
      end
   end

   // Larger tune codes lengthen the half period step by step.
   assign half_limit = 12'(HALF_BASE_CYCLES) +
      12'(lowfreq_fine_tune) * 12'(TUNE_STEP_CYCLES);

   // The oscillator ticks only while enabled; off it holds at zero.
   always_ff @(posedge clk_in) begin
      if (rst_in || !lowfreq_osc_on) begin
         half_count <= 12'h000;
         raw_tick <= 1'b0;
      end else if (half_count >= half_limit - 12'h001) begin
         half_count <= 12'h000;
         raw_tick <= 1'b1;
      end else begin
         half_count <= half_count + 12'h001;
         raw_tick <= 1'b0;
      end
   end

   lfo_divider u_div (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .tick_in(raw_tick),
      .div_sel_in(lowfreq_div_sel),
      .level_out(lfo_clk_out),
      .rise_out(div_rise),
      .fall_out(div_fall)
   );

   // Settling: the flag sets after enough oscillator ticks, and once set
   // clears only on reset or a changed divider code; disabling the
   // oscillator alone does not clear it.
   always_ff @(posedge clk_in) begin
      if (rst_in || div_change) begin
         settle_count <= 5'h00;
         lowfreq_osc_stable <= 1'b0;
      end else if (raw_tick && !lowfreq_osc_stable) begin
         if (settle_count == 5'(SETTLE_CYCLES - 1)) begin
            lowfreq_osc_stable <= 1'b1;
         end
         settle_count <= settle_count + 5'h01;
      end
   end

   // Two flip-flops put the flag in the register read path; this
   // mirrors the analog flag crossing and costs two cycles of latency.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         stable_meta <= 1'b0;
         stable_sync <= 1'b0;
      end else begin
         stable_meta <= lowfreq_osc_stable;
         stable_sync <= stable_meta;
      end
   end

   // Read data; other addresses read zero.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sfr_rdata_out <= 8'h00;
      end else if (sfr_addr_in == LFO_CTRL_ADDR) begin
         sfr_rdata_out <= {lowfreq_osc_on, stable_sync,
            lowfreq_fine_tune, lowfreq_div_sel};
      end else begin
         sfr_rdata_out <= 8'h00;
      end
   end

   // Capture events: timer 2 on falling edges, timer 3 on rising edges.
   assign t2_capture_out = t2_capture_mode_in && div_fall;
   assign t3_capture_out = t3_capture_mode_in && div_rise;

   // Capture copies the running count, both bytes, into the reload
   // registers; software subtracts successive values to find the period.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         t2_reload_out <= '0;
         t3_reload_out <= '0;
      end else begin
         if (t2_capture_out) begin
            t2_reload_out <= t2_count_in;
         end
         if (t3_capture_out) begin
            t3_reload_out <= t3_count_in;
         end
      end
   end

   // Ready never falls except after reset or a divider code change.
   property p_stable_hold;
      @(posedge clk_in) disable iff (rst_in)
      (lowfreq_osc_stable && !div_change) |=> lowfreq_osc_stable;
   endproperty
   a_stable_hold: assert property (p_stable_hold)
      else $error("Ready flag dropped without a divider change.");

   // A divider change clears ready on the next cycle.
   property p_stable_clear;
      @(posedge clk_in) disable iff (rst_in)
      div_change |=> !lowfreq_osc_stable;
   endproperty
   a_stable_clear: assert property (p_stable_clear)
      else $error("Ready flag not cleared by divider change.");

   // The read path shows the flag two cycles late.
   property p_sync_delay;
      @(posedge clk_in) disable iff (rst_in)
      ##2 stable_sync == $past(lowfreq_osc_stable, 2);
   endproperty
   a_sync_delay: assert property (p_sync_delay)
      else $error("Ready synchroniser latency wrong.");

   // No tick while disabled.
   property p_off_quiet;
      @(posedge clk_in) disable iff (rst_in)
      !lowfreq_osc_on |=> !raw_tick;
   endproperty
   a_off_quiet: assert property (p_off_quiet)
      else $error("Oscillator ticked while disabled.");

   // Timer 2 capture only on a falling output edge.
   property p_t2_edge;
      @(posedge clk_in) disable iff (rst_in)
      t2_capture_out |-> ($past(lfo_clk_out) && !lfo_clk_out);
   endproperty
   a_t2_edge: assert property (p_t2_edge)
      else $error("Timer 2 captured off a falling edge.");

   // Timer 3 capture only on a rising output edge.
   property p_t3_edge;
      @(posedge clk_in) disable iff (rst_in)
      t3_capture_out |-> (!$past(lfo_clk_out) && lfo_clk_out);
   endproperty
   a_t3_edge: assert property (p_t3_edge)
      else $error("Timer 3 captured off a rising edge.");

   // Captured reload equals the count at the event.
   property p_t2_copy;
      @(posedge clk_in) disable iff (rst_in)
      t2_capture_out |=> t2_reload_out == $past(t2_count_in);
   endproperty
   a_t2_copy: assert property (p_t2_copy)
      else $error("Timer 2 reload not loaded from count.");

   // A larger tune code gives a longer half period, so the order of
   // the codes holds for any step size from 1 to 252 cycles.
   property p_tune_mono;
      @(posedge clk_in) disable iff (rst_in)
      (lowfreq_fine_tune > $past(lowfreq_fine_tune)) |->
         half_limit > $past(half_limit);
   endproperty
   a_tune_mono: assert property (p_tune_mono)
      else $error("Tune setting does not map monotonically.");

   // Divide by one toggles the output two cycles after each raw tick:
   // one cycle to step the count and one for the output register.
   property p_div1;
      @(posedge clk_in) disable iff (rst_in)
      (raw_tick && u_div.active_sel == DIV_BY_1) |=> ##1
         lfo_clk_out != $past(lfo_clk_out);
   endproperty
   a_div1: assert property (p_div1)
      else $error("Divide by one output did not toggle.");
endmodule
`default_nettype wire

// ---- tb_lowfreq_osc_control.sv ----
`default_nettype none
module tb_lowfreq_osc_control
   import lfo_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in, rst_in, wr, m2, m3;
   logic [7:0] addr, wdata, rdata;
   logic [15:0] c2, c3, r2, r3, p_c2, p_c3, p_r2, p_r3;
   logic cap2, cap3, lfo, p_lfo, p_cap2, p_cap3, p_rst;
   int miscompares;
   int samples_checked;

   lowfreq_osc_control #(.COUNT_WIDTH(16)) dut (.clk_in(clk_in),
      .rst_in(rst_in), .sfr_addr_in(addr), .sfr_wr_in(wr),
      .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
      .t2_capture_mode_in(m2), .t3_capture_mode_in(m3),
      .t2_count_in(c2), .t3_count_in(c3), .t2_reload_out(r2),
      .t3_reload_out(r3), .t2_capture_out(cap2), .t3_capture_out(cap3),
      .lfo_clk_out(lfo));

   // The 50 MHz system clock.
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   // Counts every compare and reports a difference at once.
   task automatic check(input string name, input logic [15:0] seen,
                        input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      if (miscompares == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // One-cycle write strobe to the control register.
   task automatic wr_ctrl(input logic [7:0] d);
      @(posedge clk_in);
      addr <= LFO_CTRL_ADDR;
      wr <= 1'b1;
      wdata <= d;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask

   // Read data is registered, so it is sampled two edges after the address.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr <= a;
      repeat (2) @(posedge clk_in);
      d = rdata;
   endtask

   // Counts cycles to the next output change; a hang ends the run.
   task automatic toggle(output int n);
      logic v;
      v = lfo;
      n = 0;
      while (lfo === v) begin
         @(posedge clk_in);
         n++;
         if (n > 40000) begin
            miscompares++;
            tally_and_finish();
         end
      end
   endtask

   task automatic still(input int n);
      logic v;
      v = lfo;
      repeat (n) begin
         @(posedge clk_in);
         check("lfo_still", 16'(lfo), 16'(v));
      end
   endtask

   // Divide factor of a divider code.
   function automatic int fac(input logic [1:0] code);
      return 8 >> code;
   endfunction

   // Random timer counts and modes every cycle; captures are checked here.
   always @(posedge clk_in) begin
      if (!rst_in && !p_rst) begin
         check("t2_capture", 16'(cap2), 16'(p_lfo & ~lfo & m2));
         check("t3_capture", 16'(cap3), 16'(~p_lfo & lfo & m3));
         check("t2_reload", r2, p_cap2 ? p_c2 : p_r2);
         check("t3_reload", r3, p_cap3 ? p_c3 : p_r3);
      end
      p_rst = rst_in;
      p_lfo = lfo;
      p_cap2 = cap2;
      p_cap3 = cap3;
      p_c2 = c2;
      p_c3 = c3;
      p_r2 = r2;
      p_r3 = r3;
      m2 <= 1'($urandom);
      m3 <= 1'($urandom);
      c2 <= 16'($urandom);
      c3 <= 16'($urandom);
   end

   initial begin
      int h[3];
      int n;
      int j;
      int lo;
      int e;
      logic [7:0] d;
      logic [3:0] tn[3];
      rst_in = 1'b1;
      addr = 8'h00;
      wr = 1'b0;
      wdata = 8'h00;
      m2 = 1'b0;
      m3 = 1'b0;
      c2 = 16'h0000;
      c3 = 16'h0000;
      miscompares = 0;
      samples_checked = 0;
      void'($urandom(32'h5CB3));
      repeat (16) @(posedge clk_in);
      rst_in <= 1'b0;
      rd(LFO_CTRL_ADDR, d);
      check("ctrl_reset", 16'(d), 16'h0000);
      rd(8'h87, d);
      check("unmapped", 16'(d), 16'h0000);
      // Disabled: the ready bit cannot be written and nothing runs.
      wr_ctrl(8'h7F);
      rd(LFO_CTRL_ADDR, d);
      check("ctrl_ro", 16'(d), 16'h003F);
      still(1000);
      wr_ctrl(8'h83);
      n = 0;
      do begin
         rd(LFO_CTRL_ADDR, d);
         n++;
      end while (d[6] !== 1'b1 && n < 3000);
      check("ready_set", 16'(d), 16'h00C3);
      wr_ctrl(8'h83);
      rd(LFO_CTRL_ADDR, d);
      check("ready_same_div", 16'(d), 16'h00C3);
      // Disabling stops the output but keeps the ready flag.
      wr_ctrl(8'h03);
      rd(LFO_CTRL_ADDR, d);
      check("ready_off", 16'(d), 16'h0043);
      repeat (1000) @(posedge clk_in);
      still(2000);
      tn[0] = 4'h0;
      tn[1] = 4'(1 + $urandom % 14);
      tn[2] = 4'hF;
      // Half periods at divide by 1 for fastest, random and slowest tune.
      for (int i = 0; i < 3; i++) begin
         wr_ctrl({2'b10, tn[i], 2'b11});
         rd(LFO_CTRL_ADDR, d);
         check("ready_tune", 16'(d[6]), 16'h0001);
         repeat (4) toggle(n);
         toggle(h[i]);
      end
      check("tune_order", 16'(h[0] < h[1] && h[1] < h[2]), 16'h1);
      check("tune_fast", 16'(h[0]), 16'(HALF_BASE_CYCLES));
      e = HALF_BASE_CYCLES + 15 * TUNE_STEP_CYCLES;
      check("tune_slow", 16'(h[2]), 16'(e));
      // Every other divider code at the fastest tune. A new code takes
      // hold only at the divider's wrap, so old-length halves come first.
      for (int k = 0; k < 3; k++) begin
         wr_ctrl({6'b100000, 2'(k)});
         // The cleared flag needs two cycles to reach the read path.
         repeat (2) @(posedge clk_in);
         rd(LFO_CTRL_ADDR, d);
         check("ready_clr", 16'(d), 16'({6'b100000, 2'(k)}));
         // The half period cut by the write is not judged.
         toggle(n);
         // No half may be shorter than the shorter of old and new.
         e = fac(2'(k)) * h[0];
         lo = (k == 0) ? h[0] : e;
         j = 0;
         do begin
            toggle(n);
            check("no_runt", 16'(n >= lo), 16'h1);
            j++;
         end while (n != e && j < 20);
         check("half_found", 16'(n), 16'(e));
         repeat (2) begin
            toggle(n);
            check("half", 16'(n), 16'(e));
         end
      end
      // A second reset clears the ready flag and the output.
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      rd(LFO_CTRL_ADDR, d);
      check("ctrl_rereset", 16'(d), 16'h0000);
      check("lfo_rereset", 16'(lfo), 16'h0000);
      tally_and_finish();
   end
endmodule
`default_nettype wire
